/* File: rtl/tgc_pkg.sv */
// What this block does
// - counter increments when running and either gate use is off or gate is active
// - polarity bit 1 counts on high gate, 0 counts on low gate
// - toggle bit routes gate through toggle flop; cleared bit holds flop cleared
// - toggle flop inverts on each rising edge of polarity-adjusted gate while the counter runs
// - single-pulse bit makes the one-shot stage control the gate
// - software writes 1 to arm; hardware clears when acquisition completes
// - gate level view shows processed gate, independent of gate use enable
// - source field: 00 pin, 01 overflow, 10 comparator 1, 11 comparator 2
// - clearing run bit stops counter and clears gate flip-flop state
// - armed flag clears on falling edge of gate level view in single-pulse mode
`default_nettype none

package tgc_pkg;

	// ========================================
	// register map
	localparam logic [3:0] CTRL_ADDR   = 4'h0;
	localparam logic [3:0] RUN_ADDR    = 4'h1;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam int         USE_BIT     = 7;
	localparam int         POL_BIT     = 6;
	localparam int         TOG_BIT     = 5;
	localparam int         SPM_BIT     = 4;
	localparam int         ARM_BIT     = 3;
	localparam int         VIEW_BIT    = 2;
	localparam int         RUN_BIT     = 0;

	typedef enum logic [1:0] {
		SRC_PIN,
		SRC_OVF,
		SRC_CMP1,
		SRC_CMP2
	} tgc_src_t;

	typedef struct packed {
		logic     gateUseEnable;
		logic     gatePolaritySel;
		logic     gateToggleSel;
		logic     singlePulseSel;
		tgc_src_t gateSourceSel;
	} tgc_cfg_t;

	typedef struct packed {
		logic gatePin;
		logic timerOverflow;
		logic cmp1SyncedOut;
		logic cmp2SyncedOut;
	} tgc_gate_in_t;

endpackage : tgc_pkg

`default_nettype wire

/* File: rtl/tgc_gate_control.sv */
// Implementation choices: the placing of the registers and strobed register access.
`default_nettype none

module tgc_gate_control (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic [3:0]            regAddr,
	input  wire logic [7:0]            regWdata,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [7:0]            regRdata,
	input  wire tgc_pkg::tgc_gate_in_t gateIn,
	output logic                       countInc
);
	import tgc_pkg::*;

	// ========================================
	// control state
	tgc_cfg_t cfg, next_cfg;
	logic     counterRun, next_counterRun;
	logic     pulseArmedFlag, next_pulseArmedFlag;
	logic     toggleFlop, next_toggleFlop;
	logic     polPrev, next_polPrev;
	logic     spmLatch, next_spmLatch;
	logic     viewPrev, next_viewPrev;
	logic [7:0] next_regRdata;

	// ========================================
	// gate chain
	logic rawGate;
	logic polGate;
	logic togGate;
	logic gateLevelView;

	always_comb
	begin
		case (cfg.gateSourceSel)
			SRC_PIN:  rawGate = gateIn.gatePin;
			SRC_OVF:  rawGate = gateIn.timerOverflow;
			SRC_CMP1: rawGate = gateIn.cmp1SyncedOut;
			SRC_CMP2: rawGate = gateIn.cmp2SyncedOut;
			default:  rawGate = 1'b0;
		endcase
		polGate = cfg.gatePolaritySel ? rawGate : ~rawGate;
		togGate = cfg.gateToggleSel ? toggleFlop : polGate;
		// one-shot: gate opens only while armed and the latch caught an active level
		gateLevelView = cfg.singlePulseSel ? (togGate & spmLatch) : togGate;
	end

	// count enable; gate use is ignored when the run bit is low
	assign countInc = counterRun & (~cfg.gateUseEnable | gateLevelView);

	// ========================================
	// next state
	always_comb
	begin
		next_cfg            = cfg;
		next_counterRun     = counterRun;
		next_pulseArmedFlag = pulseArmedFlag;
		next_toggleFlop     = toggleFlop;
		// edge detectors track in every mode, so turning toggle mode on meets no stale edge
		next_polPrev        = polGate;
		next_viewPrev       = gateLevelView;
		next_spmLatch       = spmLatch;
		next_regRdata       = 8'h00;

		if (regWrite)
		begin
			if (regAddr == CTRL_ADDR)
			begin
				next_cfg.gateUseEnable   = regWdata[USE_BIT];
				next_cfg.gatePolaritySel = regWdata[POL_BIT];
				next_cfg.gateToggleSel   = regWdata[TOG_BIT];
				next_cfg.singlePulseSel  = regWdata[SPM_BIT];
				next_cfg.gateSourceSel   = tgc_src_t'(regWdata[1:0]);
			end
			else if (regAddr == RUN_ADDR)
				next_counterRun = regWdata[RUN_BIT];
		end

		// a stop write clears chain state at the same edge as the run bit itself
		if (!cfg.gateToggleSel || !counterRun || !next_counterRun)
			next_toggleFlop = 1'b0;
		else if (polGate && !polPrev)
			next_toggleFlop = ~toggleFlop;

		// latch opens on the first active level of the pre-one-shot gate while armed
		if (!counterRun || !next_counterRun || !cfg.singlePulseSel || !pulseArmedFlag)
			next_spmLatch = 1'b0;
		else if (togGate)
			next_spmLatch = 1'b1;

		// hardware clear ends the interval; a same-cycle arm write wins
		if (cfg.singlePulseSel && viewPrev && !gateLevelView)
			next_pulseArmedFlag = 1'b0;
		if (regWrite && regAddr == CTRL_ADDR && regWdata[ARM_BIT])
			next_pulseArmedFlag = 1'b1;

		if (regRead)
		begin
			if (regAddr == CTRL_ADDR)
				next_regRdata = {cfg.gateUseEnable, cfg.gatePolaritySel, cfg.gateToggleSel,
					cfg.singlePulseSel, pulseArmedFlag, gateLevelView, cfg.gateSourceSel};
			else if (regAddr == RUN_ADDR)
				next_regRdata = {7'h00, counterRun};
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg            <= tgc_cfg_t'(6'h00);
			counterRun     <= 1'b0;
			pulseArmedFlag <= 1'b0;
			toggleFlop     <= 1'b0;
			polPrev        <= 1'b0;
			spmLatch       <= 1'b0;
			viewPrev       <= 1'b0;
			regRdata       <= 8'h00;
		end
		else
		begin
			cfg            <= next_cfg;
			counterRun     <= next_counterRun;
			pulseArmedFlag <= next_pulseArmedFlag;
			toggleFlop     <= next_toggleFlop;
			polPrev        <= next_polPrev;
			spmLatch       <= next_spmLatch;
			viewPrev       <= next_viewPrev;
			regRdata       <= next_regRdata;
		end
	end

	// ========================================
	// checks
	count_free_a : assert property (@(posedge clk) disable iff (!arst_n)
		(counterRun && !cfg.gateUseEnable) |-> countInc)
		else $error("counter not counting with gate unused");
	count_gated_a : assert property (@(posedge clk) disable iff (!arst_n)
		(counterRun && cfg.gateUseEnable) |-> (countInc == gateLevelView))
		else $error("count enable differs from gate view");
	count_off_a : assert property (@(posedge clk) disable iff (!arst_n)
		!counterRun |-> (!countInc && !toggleFlop))
		else $error("counter active while stopped");
	pol_plain_a : assert property (@(posedge clk) disable iff (!arst_n)
		(!cfg.gateToggleSel && !cfg.singlePulseSel) |-> (gateLevelView == (rawGate == cfg.gatePolaritySel)))
		else $error("polarity not applied");
	tog_clear_a : assert property (@(posedge clk) disable iff (!arst_n)
		!cfg.gateToggleSel |=> !toggleFlop)
		else $error("toggle flop not held cleared");
	tog_flip_a : assert property (@(posedge clk) disable iff (!arst_n)
		(counterRun && cfg.gateToggleSel && polGate && !polPrev && !(regWrite && regAddr == RUN_ADDR))
		|=> (toggleFlop != $past(toggleFlop)))
		else $error("toggle flop missed rising edge");
	spm_idle_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.singlePulseSel && !spmLatch) |-> !gateLevelView)
		else $error("one-shot gate open without trigger");
	arm_done_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.singlePulseSel && viewPrev && !gateLevelView && !(regWrite && regAddr == CTRL_ADDR))
		|=> !pulseArmedFlag)
		else $error("armed flag not cleared at gate fall");
	arm_set_a : assert property (@(posedge clk) disable iff (!arst_n)
		(regWrite && regAddr == CTRL_ADDR && regWdata[ARM_BIT]) |=> pulseArmedFlag)
		else $error("arm write lost");
	view_read_a : assert property (@(posedge clk) disable iff (!arst_n)
		(regRead && regAddr == CTRL_ADDR) |=> (regRdata[VIEW_BIT] == $past(gateLevelView)))
		else $error("gate view readback wrong");

	// ========================================
	// chain checks
	// these read internal nets, so a broken stage shows here before the count does
	src_pin_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.gateSourceSel == SRC_PIN) |-> (rawGate == gateIn.gatePin))
		else $error("pin source not selected");
	src_ovf_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.gateSourceSel == SRC_OVF) |-> (rawGate == gateIn.timerOverflow))
		else $error("overflow source not selected");
	src_cmp1_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.gateSourceSel == SRC_CMP1) |-> (rawGate == gateIn.cmp1SyncedOut))
		else $error("comparator 1 source not selected");
	src_cmp2_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.gateSourceSel == SRC_CMP2) |-> (rawGate == gateIn.cmp2SyncedOut))
		else $error("comparator 2 source not selected");
	tog_route_a : assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.gateToggleSel && !cfg.singlePulseSel) |-> (gateLevelView == toggleFlop))
		else $error("toggle flop not routed to gate");
	tog_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
		(counterRun && cfg.gateToggleSel && !(polGate && !polPrev) && !(regWrite && regAddr == RUN_ADDR))
		|=> (toggleFlop == $past(toggleFlop)))
		else $error("toggle flop moved without rising edge");
	spm_pass_a : assert property (@(posedge clk) disable iff (!arst_n)
		!cfg.singlePulseSel |-> (gateLevelView == togGate))
		else $error("one-shot stage active while disabled");
	spm_open_a : assert property (@(posedge clk) disable iff (!arst_n)
		(counterRun && cfg.singlePulseSel && pulseArmedFlag && togGate && !(regWrite && regAddr == RUN_ADDR))
		|=> spmLatch)
		else $error("one-shot latch missed active gate");

	// ========================================
	// register checks
	cfg_write_a : assert property (@(posedge clk) disable iff (!arst_n)
		(regWrite && regAddr == CTRL_ADDR) |=> (cfg.gateSourceSel == $past(regWdata[1:0])))
		else $error("source field write lost");
	src_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
		!(regWrite && regAddr == CTRL_ADDR) |=> $stable(cfg))
		else $error("settings changed without control write");
	arm_hold_a : assert property (@(posedge clk) disable iff (!arst_n)
		(pulseArmedFlag && !(cfg.singlePulseSel && viewPrev && !gateLevelView))
		|=> pulseArmedFlag)
		else $error("armed flag cleared early");
	run_stop_a : assert property (@(posedge clk) disable iff (!arst_n)
		(regWrite && regAddr == RUN_ADDR && !regWdata[RUN_BIT]) |=> (!counterRun && !toggleFlop && !spmLatch))
		else $error("stop write left gate state set");
	run_read_a : assert property (@(posedge clk) disable iff (!arst_n)
		(regRead && regAddr == RUN_ADDR) |=> (regRdata == {7'h00, $past(counterRun)}))
		else $error("run readback wrong");
	read_idle_a : assert property (@(posedge clk) disable iff (!arst_n)
		!regRead |=> (regRdata == 8'h00))
		else $error("read data outside read cycle");

endmodule : tgc_gate_control

`default_nettype wire

/* File: dv/tgc_gate_src.sv */
`default_nettype none

// ========================================
// gate sources
// unselected sources show the opposite level, so a wrong pick is seen
module tgc_gate_src import tgc_pkg::*; (
	input  wire logic [1:0]            sel,
	input  wire logic                  lvl,
	output var  tgc_pkg::tgc_gate_in_t gateIn
);
	timeunit 1ns;
	timeprecision 1ps;

	always_comb
	begin
		gateIn = {4{~lvl}};
		gateIn[3 - sel] = lvl;
	end
endmodule : tgc_gate_src

`default_nettype wire

/* File: dv/timer1_gate_control_bench.sv */
`default_nettype none

module timer1_gate_control_bench import tgc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic         clk = 0, arst_n = 0, regWrite = 0, regRead = 0, lvl = 1, countInc;
	logic [3:0]   regAddr = '0;
	logic [7:0]   regWdata = '0, regRdata, rdv;
	logic [1:0]   src = '0;
	tgc_gate_in_t gateIn;
	int           num_errors = 0, compares = 0;
	// control, run, gate level, expected count enable
	logic [10:0]  rows [12] = '{11'h005, 11'h402, 11'h000, 11'h607, 11'h60f, 11'h614,
		11'h61f, 11'h405, 11'h40e, 11'h415, 11'h41d, 11'h61c};

	always #10 clk = ~clk;

	tgc_gate_src tgc_gate_src_inst (.sel(src), .lvl(lvl), .gateIn(gateIn));
	tgc_gate_control tgc_gate_control_inst (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.gateIn(gateIn), .countInc(countInc));

	// ========================================
	// bus and compare tasks
	task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic ck(logic e);
		chk("countInc", {7'h0, e}, {7'h0, countInc});
	endtask : ck

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		if (a == CTRL_ADDR)
			src <= d[1:0];
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr

	task automatic rd(logic [3:0] a);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		rdv = regRdata;
	endtask : rd

	// gives the edge detector and the one-shot latch time to settle
	task automatic step(logic v);
		@(posedge clk);
		lvl <= v;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : step

	task automatic finish_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// ========================================
	// tests
	initial
	begin
		repeat (3) @(posedge clk);
		ck(1'b0);
		arst_n <= 1'b1;
		rd(CTRL_ADDR);
		chk("ctrl", CTRL_RESET, rdv);
		foreach (rows[i])
		begin
			wr(CTRL_ADDR, rows[i][10:3]);
			wr(RUN_ADDR, {7'h0, rows[i][2]});
			step(rows[i][1]);
			ck(rows[i][0]);
		end
		wr(CTRL_ADDR, 8'h40);
		step(1'b1);
		rd(CTRL_ADDR);
		chk("ctrl", 8'h44, rdv);
		wr(CTRL_ADDR, 8'he0);
		step(1'b0);
		ck(1'b0);
		step(1'b1);
		ck(1'b1);
		step(1'b0);
		ck(1'b1);
		step(1'b1);
		ck(1'b0);
		step(1'b0);
		step(1'b1);
		wr(RUN_ADDR, 8'h00);
		@(negedge clk);
		ck(1'b0);
		rd(RUN_ADDR);
		chk("run", 8'h00, rdv);
		wr(RUN_ADDR, 8'h01);
		@(negedge clk);
		ck(1'b0);
		rd(RUN_ADDR);
		chk("run", 8'h01, rdv);
		step(1'b0);
		wr(CTRL_ADDR, 8'hd8);
		rd(CTRL_ADDR);
		chk("ctrl", 8'hd8, rdv);
		ck(1'b0);
		step(1'b1);
		ck(1'b1);
		step(1'b0);
		ck(1'b0);
		rd(CTRL_ADDR);
		chk("ctrl", 8'hd0, rdv);
		step(1'b1);
		ck(1'b0);
		wr(4'h5, 8'hff);
		rd(4'h5);
		chk("unmapped", 8'h00, rdv);
		rd(CTRL_ADDR);
		chk("ctrl", 8'hd0, rdv);
		// mid-run reset must drop the run bit and the count enable at once
		wr(CTRL_ADDR, 8'h00);
		@(negedge clk);
		ck(1'b1);
		@(posedge clk);
		arst_n <= 1'b0;
		@(negedge clk);
		ck(1'b0);
		@(posedge clk);
		arst_n <= 1'b1;
		rd(CTRL_ADDR);
		chk("ctrl", CTRL_RESET, rdv);
		rd(RUN_ADDR);
		chk("run", 8'h00, rdv);
		finish_test();
	end

	initial
	begin
		#100000;
		num_errors++;
		finish_test();
	end
endmodule : timer1_gate_control_bench

`default_nettype wire
